// ---- hw/serial_status_register.sv ----
// Serial front end and primary status/configuration register.
// Assumes csN, sck, si and wpN are synchronous to core_clk and that sck
// runs well below core_clk/2 so every edge is seen.
`timescale 1ns/1ps
//
// Contract
// - Guard flag bit 7 is nonvolatile, written by status write, read back.
// - Status write blocked when guard flag set and protect pin low.
// - Quad command flag bit 6 is volatile, zero after power-up.
// - Quad enter sets flag; single return or dual enter clears it.
// - Status write ignores bit 6; flag still reads back.
// - Both status registers show quad flag from one shared bit.
// - Latency bits 5:4 nonvolatile, writable and readable, set read dummies.
// - Protect bits 3:2 nonvolatile, writable and readable, size protected area.
// - Write-enable latch bit 1 volatile, zero at power-up, one allows writes.
// - Write enable sets latch, write disable clears; host enables first.
// - Latch readable but status write data bit 1 ignored.
// - Latch clears at power-up, write disable, and wake from sleep.
// - Latch stays set after status write or any array write.
// - Bit 0 always reads zero; writes to it ignored.
module serial_status_register
    import status_reg_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       csN,
    input  wire logic       sck,
    input  wire logic       si,
    input  wire logic       wpN,
    output logic            soData,
    output logic            soOe,
    output logic            quadWideCmdFlag,
    output logic            secondQuadWideCmdFlag,
    output logic            dualModeFlag,
    output logic [1:0]      latencySelect,
    output logic [1:0]      protectRegion,
    output logic            writeEnableLatch,
    output logic            statusWriteGuardFlag,
    output logic            sleeping
);

    serialState_t state_q, state_d;
    logic [2:0]   bitCnt_q;
    logic [7:0]   inShift_q;
    logic [7:0]   outShift_q;
    logic         sckPrev_q;
    logic         csPrev_q;
    logic         qwc_q;
    logic         dual_q;
    logic         wel_q;
    logic         asleep_q;
    logic         so_q;
    logic         soOe_q;
    nvBits_t      nvRd;
    nvBits_t      nvWrData;

    wire logic       sckRise   = sckPrev_q == 1'b0 && sck == 1'b1;
    wire logic       sckFall   = sckPrev_q == 1'b1 && sck == 1'b0;
    wire logic       csFall    = csPrev_q == 1'b1 && csN == 1'b0;
    wire logic       active    = !csN && !asleep_q && !csFall;
    wire logic       byteDone  = active && sckRise &&
                                 bitCnt_q == LAST_BIT_INDEX;
    wire logic [7:0] nextByte  = {inShift_q[6:0], si};
    wire logic       opDone    = byteDone && state_q == ST_OPCODE;
    wire logic       dataDone  = byteDone && state_q == ST_WDATA;

    wire logic isWren   = opDone && nextByte == OP_WRITE_ENABLE;
    wire logic isWrdi   = opDone && nextByte == OP_WRITE_DISABLE;
    wire logic isRdsr   = opDone && nextByte == OP_STATUS_READ;
    wire logic isRdsr2  = opDone && nextByte == OP_STATUS2_READ;
    wire logic isWrsr   = opDone && nextByte == OP_STATUS_WRITE;
    wire logic isQuad   = opDone && nextByte == OP_QUAD_ENTER;
    wire logic isDual   = opDone && nextByte == OP_DUAL_ENTER;
    wire logic isSingle = opDone && nextByte == OP_SINGLE_RETURN;
    wire logic isSleep  = opDone && (nextByte == OP_DEEP_SLEEP ||
                                     nextByte == OP_HIBERNATE);

    // Pin low with guard set locks the status register
    wire logic writeBlocked = nvRd.guard && !wpN;
    wire logic nvCommit     = dataDone && wel_q && !writeBlocked;

    // Bits 6, 1 and 0 of the incoming byte are dropped here
    assign nvWrData.guard   = nextByte[GUARD_BIT];
    assign nvWrData.latency = {nextByte[LAT_HI_BIT],
                               nextByte[LAT_LO_BIT]};
    assign nvWrData.protect = {nextByte[PROT_HI_BIT],
                               nextByte[PROT_LO_BIT]};

    logic [7:0] statusImage;
    logic [7:0] status2Image;

    always_comb begin
        statusImage              = 8'h00;
        statusImage[GUARD_BIT]   = nvRd.guard;
        statusImage[QWC_BIT]     = qwc_q;
        statusImage[LAT_HI_BIT]  = nvRd.latency[1];
        statusImage[LAT_LO_BIT]  = nvRd.latency[0];
        statusImage[PROT_HI_BIT] = nvRd.protect[1];
        statusImage[PROT_LO_BIT] = nvRd.protect[0];
        statusImage[WEL_BIT]     = wel_q;
        statusImage[ZERO_BIT]    = 1'b0;
    end

    always_comb begin
        status2Image               = 8'h00;
        status2Image[SR2_QWC_BIT]  = qwc_q;
        status2Image[SR2_DUAL_BIT] = dual_q;
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OPCODE: begin
                if (isRdsr || isRdsr2) begin
                    state_d = ST_READ;
                end else if (isWrsr) begin
                    state_d = ST_WDATA;
                end else if (opDone) begin
                    state_d = ST_SKIP;
                end
            end
            ST_WDATA: begin
                if (dataDone) begin
                    state_d = ST_SKIP;
                end
            end
            ST_READ:  state_d = ST_READ;
            ST_SKIP:  state_d = ST_SKIP;
            default:  state_d = ST_SKIP;
        endcase
    end

    nv_status_store u_store (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .write_enable_cmd     (nvCommit),
        .wrData   (nvWrData),
        .rdData   (nvRd)
    );

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sckPrev_q <= 1'b0;
            csPrev_q  <= 1'b1;
        end else begin
            sckPrev_q <= sck;
            csPrev_q  <= csN;
        end
    end

    // Frame engine; deselect aborts any partial byte
    always_ff @(posedge core_clk) begin
        if (!rst_n || csN || !active) begin
            state_q   <= ST_OPCODE;
            bitCnt_q  <= FIRST_BIT_INDEX;
            inShift_q <= SHIFT_RESET;
        end else if (sckRise) begin
            state_q   <= state_d;
            bitCnt_q  <= bitCnt_q + 3'h1;
            inShift_q <= nextByte;
        end
    end

    // Loaded on the opcode edge, repeats the same byte while selected
    always_ff @(posedge core_clk) begin
        if (!rst_n || csN) begin
            outShift_q <= SHIFT_RESET;
            so_q       <= 1'b0;
            soOe_q     <= 1'b0;
        end else if (isRdsr) begin
            outShift_q <= statusImage;
            soOe_q     <= 1'b1;
        end else if (isRdsr2) begin
            outShift_q <= status2Image;
            soOe_q     <= 1'b1;
        end else if (sckFall && state_q == ST_READ) begin
            so_q       <= outShift_q[7];
            outShift_q <= {outShift_q[6:0], outShift_q[7]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            qwc_q  <= QWC_RESET;
            dual_q <= DUAL_RESET;
        end else if (isQuad) begin
            qwc_q  <= 1'b1;
            dual_q <= 1'b0;
        end else if (isDual) begin
            qwc_q  <= 1'b0;
            dual_q <= 1'b1;
        end else if (isSingle) begin
            qwc_q  <= 1'b0;
            dual_q <= 1'b0;
        end
    end

    // Array writes and status writes leave the latch alone on purpose
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wel_q    <= WEL_RESET;
            asleep_q <= 1'b0;
        end else if (asleep_q && csFall) begin
            wel_q    <= 1'b0;
            asleep_q <= 1'b0;
        end else if (isWren) begin
            wel_q    <= 1'b1;
        end else if (isWrdi) begin
            wel_q    <= 1'b0;
        end else if (isSleep) begin
            asleep_q <= 1'b1;
        end
    end

    assign soData                = so_q;
    assign soOe                  = soOe_q;
    assign quadWideCmdFlag       = qwc_q;
    assign secondQuadWideCmdFlag = qwc_q;
    assign dualModeFlag          = dual_q;
    assign latencySelect         = nvRd.latency;
    assign protectRegion         = nvRd.protect;
    assign writeEnableLatch      = wel_q;
    assign statusWriteGuardFlag  = nvRd.guard;
    assign sleeping              = asleep_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // One shift step of a status read frame
    sequence readShift;
        sckFall && state_q == ST_READ && !csN;
    endsequence

    wel_set_a: assert property (isWren && !asleep_q |=> wel_q)
        else $error("latch not set by write enable");
    wel_clear_a: assert property (isWrdi |=> !wel_q)
        else $error("latch not cleared by write disable");
    quad_enter_a: assert property (isQuad |=> qwc_q && !dual_q)
        else $error("quad flag not set by quad enter");
    quad_leave_a: assert property ((isDual || isSingle) |=> !qwc_q)
        else $error("quad flag not cleared");
    status_write_cmd_keeps_wel_a: assert property (dataDone |=> $stable(wel_q))
        else $error("status write changed the latch");
    status_write_cmd_ignores_qwc_a: assert property (dataDone |=> $stable(qwc_q))
        else $error("status write changed quad flag");
    blocked_write_a: assert property (
        dataDone && writeBlocked |-> ##2 $stable(nvRd))
        else $error("blocked status write took effect");
    // Write data is taken from the commit edge; later bits may follow
    write_lands_a: assert property (
        nvCommit |-> ##2 nvRd == $past(nvWrData, 2))
        else $error("status write did not land");
    zero_bit_a: assert property (
        isRdsr |=> outShift_q[ZERO_BIT] == 1'b0)
        else $error("bit zero not zero");
    msb_first_a: assert property (
        readShift |=> so_q == $past(outShift_q[7]))
        else $error("status not shifted msb first");
    mirror_a: assert property (
        quadWideCmdFlag == secondQuadWideCmdFlag)
        else $error("quad flag mirrors differ");
    wake_clear_a: assert property (
        asleep_q && csFall |=> !wel_q && !asleep_q)
        else $error("latch survived wake");

endmodule

// ---- shared/status_reg_pkg.sv ----
// Constants and types for the primary status and configuration register.
// Assumes all serial pins are already synchronous to core_clk.
package status_reg_pkg;

    localparam int GUARD_BIT    = 7;
    localparam int QWC_BIT      = 6;
    localparam int LAT_HI_BIT   = 5;
    localparam int LAT_LO_BIT   = 4;
    localparam int PROT_HI_BIT  = 3;
    localparam int PROT_LO_BIT  = 2;
    localparam int WEL_BIT      = 1;
    localparam int ZERO_BIT     = 0;
    localparam int SR2_QWC_BIT  = 6;
    localparam int SR2_DUAL_BIT = 5;

    localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
    localparam logic [7:0] OP_STATUS_READ    = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE   = 8'h01;
    localparam logic [7:0] OP_STATUS2_READ   = 8'h35;
    localparam logic [7:0] OP_QUAD_ENTER     = 8'h38;
    localparam logic [7:0] OP_DUAL_ENTER     = 8'h37;
    localparam logic [7:0] OP_SINGLE_RETURN  = 8'hFF;
    localparam logic [7:0] OP_DEEP_SLEEP     = 8'hBA;
    localparam logic [7:0] OP_HIBERNATE      = 8'hB9;

    localparam logic [2:0] LAST_BIT_INDEX    = 3'h7;
    localparam logic [2:0] FIRST_BIT_INDEX   = 3'h0;
    localparam logic [4:0] NV_RESET          = 5'h00;
    localparam logic       QWC_RESET         = 1'b0;
    localparam logic       DUAL_RESET        = 1'b0;
    localparam logic       WEL_RESET         = 1'b0;
    localparam logic [7:0] SHIFT_RESET       = 8'h00;

    typedef enum logic [1:0] {
        ST_OPCODE = 2'b00,
        ST_WDATA  = 2'b01,
        ST_READ   = 2'b10,
        ST_SKIP   = 2'b11
    } serialState_t;

    typedef struct packed {
        logic       guard;
        logic [1:0] latency;
        logic [1:0] protect;
    } nvBits_t;

endpackage

// ---- hw/nv_status_store.sv ----
// Storage cell for the nonvolatile status bits, registered read port.
// Assumes the caller qualifies writes; rst_n stands for the shipped state.
`timescale 1ns/1ps
module nv_status_store
    import status_reg_pkg::*;
(
    input  wire logic    core_clk,
    input  wire logic    rst_n,
    input  wire logic    write_enable_cmd,
    input  wire nvBits_t wrData,
    output nvBits_t      rdData
);

    nvBits_t store_q;
    nvBits_t rdData_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            store_q  <= nvBits_t'(NV_RESET);
            rdData_q <= nvBits_t'(NV_RESET);
        end else begin
            if (write_enable_cmd) begin
                store_q <= wrData;
            end
            rdData_q <= store_q;
        end
    end

    assign rdData = rdData_q;

endmodule

// ---- verif/spi_host_model.sv ----
// Host side of the serial bus: single-wire command frames, MSB first.
// Assumes the device samples pins on core_clk and shifts out on sck fall.
`timescale 1ns/1ps
module spi_host_model
    import status_reg_pkg::*;
(
    input  wire logic core_clk,
    output logic      csN,
    output logic      sck,
    output logic      si,
    input  wire logic soData
);
    initial begin
        csN = 1'b1;
        sck = 1'b0;
        si  = 1'b0;
    end

    // Each sck level held two cycles so the device sees every edge
    task automatic frame(input logic [15:0] tx, input int n,
                         output logic [7:0] rx);
        rx = 8'h00;
        csN <= 1'b0;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < n; i++) begin
            si  <= tx[15-i];
            sck <= 1'b0;
            repeat (2) @(posedge core_clk);
            if (i >= 8) rx = {rx[6:0], soData};
            sck <= 1'b1;
            repeat (2) @(posedge core_clk);
        end
        sck <= 1'b0;
        repeat (2) @(posedge core_clk);
        csN <= 1'b1;
        si  <= ~si;  // Released line must not keep a stale level
        repeat (3) @(posedge core_clk);
    endtask

    task automatic statusWrite(input logic [7:0] d);
        logic [7:0] r;
        frame({OP_WRITE_ENABLE, 8'h00}, 8, r);
        frame({OP_STATUS_WRITE, d}, 16, r);
    endtask
endmodule

// ---- verif/serial_memory_status_register_test.sv ----
// Self-checking bench for the serial status register.
// Assumes the host model drives all serial pins on core_clk rising edges.
`timescale 1ns/1ps
module serial_memory_status_register_test;
    import status_reg_pkg::*;
    logic       core_clk;
    logic       rst_n;
    logic       wpN;
    logic       csN;
    logic       sck;
    logic       si;
    logic       soData;
    logic       soOe;
    logic       dualFlag;
    logic       quadFlag;
    logic       quadFlag2;
    logic       welFlag;
    logic       guardFlag;
    logic       sleeping;
    logic [1:0] latency;
    logic [1:0] protect;
    int         fails;
    int         checksDone;
    int         cycles;
    int         oeCycles;

    serial_status_register u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .csN(csN), .sck(sck),
        .si(si), .wpN(wpN), .soData(soData), .soOe(soOe),
        .quadWideCmdFlag(quadFlag), .secondQuadWideCmdFlag(quadFlag2),
        .dualModeFlag(dualFlag), .latencySelect(latency),
        .protectRegion(protect), .writeEnableLatch(welFlag),
        .statusWriteGuardFlag(guardFlag), .sleeping(sleeping)
    );
    spi_host_model u_host (
        .core_clk(core_clk), .csN(csN), .sck(sck), .si(si),
        .soData(soData)
    );

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] op);
        logic [7:0] r;
        u_host.frame({op, 8'h00}, 8, r);
    endtask

    task automatic expectSr(input logic [7:0] exp);
        logic [7:0] r;
        u_host.frame({OP_STATUS_READ, 8'h00}, 16, r);
        chk(r, exp);
    endtask

    task automatic expectSr2(input logic [7:0] exp);
        logic [7:0] r;
        u_host.frame({OP_STATUS2_READ, 8'h00}, 16, r);
        chk(r, exp);
    endtask

    task automatic tReset;
        expectSr(8'h00);
    endtask

    task automatic tLatch;
        cmd(OP_WRITE_ENABLE);
        chk({7'h00, welFlag}, 8'h01);
        expectSr(8'h02);
        cmd(OP_WRITE_DISABLE);
        expectSr(8'h00);
    endtask

    task automatic tWrite;
        logic [7:0] r;
        u_host.statusWrite(8'hFF);
        expectSr(8'hBE);
        chk({3'h0, guardFlag, latency, protect}, 8'h1F);
        cmd(OP_WRITE_DISABLE);
        u_host.frame({OP_STATUS_WRITE, 8'h00}, 16, r);
        expectSr(8'hBC);
    endtask

    task automatic tGuard;
        wpN <= 1'b0;
        u_host.statusWrite(8'h00);
        expectSr(8'hBE);
        wpN <= 1'b1;
        u_host.statusWrite(8'h54);
        expectSr(8'h16);
    endtask

    task automatic tQuad;
        cmd(OP_QUAD_ENTER);
        chk({6'h00, quadFlag, quadFlag2}, 8'h03);
        expectSr(8'h56);
        cmd(OP_SINGLE_RETURN);
        chk({6'h00, quadFlag, quadFlag2}, 8'h00);
        cmd(OP_QUAD_ENTER);
        cmd(OP_DUAL_ENTER);
        chk({6'h00, quadFlag, quadFlag2}, 8'h00);
    endtask

    task automatic tStatus2;
        int n;
        cmd(OP_QUAD_ENTER);
        n = oeCycles;
        expectSr2(8'h40);
        chk({7'h00, oeCycles != n}, 8'h01);
        chk({7'h00, soOe}, 8'h00);
        cmd(OP_DUAL_ENTER);
        chk({7'h00, dualFlag}, 8'h01);
        expectSr2(8'h20);
        n = oeCycles;
        cmd(OP_SINGLE_RETURN);
        chk({6'h00, dualFlag, oeCycles != n}, 8'h00);
    endtask

    task automatic tSleep;
        logic [7:0] ops [2];
        ops = '{OP_DEEP_SLEEP, OP_HIBERNATE};
        foreach (ops[k]) begin
            cmd(OP_WRITE_ENABLE);
            cmd(ops[k]);
            chk({7'h00, sleeping}, 8'h01);
            // Wake clears the latch before the waking frame is decoded
            expectSr(8'h14);
            chk({5'h00, sleeping, welFlag, quadFlag}, 8'h00);
        end
    endtask

    task automatic summarize;
        $display("checks %0d fails %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Whole run is under two thousand cycles; this ceiling only cuts a hang
    always @(posedge core_clk) begin
        cycles++;
        if (soOe) begin
            oeCycles++;
        end
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end

    initial begin
        rst_n = 1'b0;
        wpN   = 1'b1;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        tReset();
        tLatch();
        tWrite();
        tGuard();
        tQuad();
        tStatus2();
        tSleep();
        summarize();
    end
endmodule
